//--- core/usb_ctl.sv
// USB control bits: enable, frame marker, ping-pong reset, host reset, resume.
// Assumes an APB master on core_clk_in and a token engine fed by token pulses.
//
// Summary of operation
// [R1] Writing one to bit 1 returns every buffer pointer to even banks.
// [R2] Device mode: bit 0 enables the USB module and its circuitry.
// [R3] Host mode: bit 0 set sends a frame marker every millisecond.
// [R4] Any change of the host mode field resets all host control logic.
// [R5] Software holds resume 10 ms as function, 25 ms as host, then clears.
// [R6] Host mode: clearing resume appends a low-speed end of packet.
// [R7] Software waits for token busy to clear before the next token command.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "usb_ctl_defs.svh"

module usb_ctl #(
  parameter int unsigned FRAME_CYCLES = `FRAME_CYCLES,
  parameter int unsigned NUM_EP       = 16
) (
  input  wire logic                   core_clk_in,   // Core clock
  input  wire logic                   rst_in,        // Sync reset, high
  input  wire usb_ctl_pkg::apb_req_s  apb_in,        // APB request
  output usb_ctl_pkg::apb_rsp_s       apb_out,       // APB answer
  output logic                        module_en_out, // Device module enable
  output logic                        sof_out,       // Frame marker pulse
  output logic                        host_rst_out,  // Host logic reset pulse
  output logic                        resume_out,    // Resume signalling
  output logic                        eop_out,       // Low-speed EOP drive
  output logic [NUM_EP-1:0]           odd_ptr_out,   // Odd buffer pointers
  output logic                        token_out,     // Token start pulse
  output logic [7:0]                  token_cmd_out  // Token command
);
  import usb_ctl_pkg::*;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit_ctrl;
  logic        hit_host;
  logic        hit_tok;
  logic        hit_stat;
  logic        mapped;
  assign acc      = apb_in.psel && apb_in.penable;
  // Writes land only at the edge where the master sees pready high
  assign wr       = acc && apb_in.pwrite && apb_out.pready;
  assign rd       = acc && !apb_in.pwrite;
  assign hit_ctrl = apb_in.paddr == `OFF_USB_CONTROL;
  assign hit_host = apb_in.paddr == `OFF_HOST_CONFIG;
  assign hit_tok  = apb_in.paddr == `OFF_TOKEN_CMD;
  assign hit_stat = apb_in.paddr == `OFF_LINK_STATUS;
  assign mapped   = hit_ctrl || hit_host || hit_tok || hit_stat;

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  logic              enable_q;
  logic              enable_d;
  logic              resume_q;
  logic              resume_d;
  logic              host_mode_q;
  logic              host_mode_d;
  logic              ctrl_wr;
  logic              host_toggle;
  logic              pp_reset;
  assign ctrl_wr     = wr && hit_ctrl;
  assign enable_d    = ctrl_wr ? apb_in.pwdata[`BIT_ENABLE] : enable_q;
  assign resume_d    = ctrl_wr ? apb_in.pwdata[`BIT_RESUME] : resume_q;
  assign host_mode_d = (wr && hit_host) ? apb_in.pwdata[`BIT_HOST_MODE] : host_mode_q;
  assign host_toggle = host_mode_d != host_mode_q; // R4
  assign pp_reset    = ctrl_wr && apb_in.pwdata[`BIT_PP_RESET]; // R1

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      enable_q    <= 1'b0;
      resume_q    <= 1'b0;
      host_mode_q <= 1'b0;
    end else begin
      enable_q    <= enable_d;
      resume_q    <= resume_d;
      host_mode_q <= host_mode_d;
    end
  end

  // --------------------------------------------------------------------------
  // Host reset and module enable
  // --------------------------------------------------------------------------
  logic host_rst_q;
  logic host_rst_d;
  logic module_en_q;
  logic module_en_d;
  assign host_rst_d  = host_toggle; // R4
  assign module_en_d = enable_d && !host_mode_d; // R2

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      host_rst_q  <= 1'b0;
      module_en_q <= 1'b0;
    end else begin
      host_rst_q  <= host_rst_d;
      module_en_q <= module_en_d;
    end
  end

  // --------------------------------------------------------------------------
  // Ping-pong pointers
  // --------------------------------------------------------------------------
  logic [NUM_EP-1:0] odd_ptr_q;
  logic [NUM_EP-1:0] odd_ptr_d;
  logic              tok_wr;
  logic [3:0]        tok_ep;
  assign tok_ep = apb_in.pwdata[3:0];

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ptr
      // An accepted token command flips its endpoint's pointer; reset forces even
      assign odd_ptr_d[g] = pp_reset ? 1'b0 :  // R1
                            (tok_wr && tok_ep == 4'(g)) ? !odd_ptr_q[g] : odd_ptr_q[g];
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      odd_ptr_q <= '0;
    end else begin
      odd_ptr_q <= odd_ptr_d;
    end
  end

  // --------------------------------------------------------------------------
  // Token command and busy flag
  // --------------------------------------------------------------------------
  logic       busy_q;
  logic       busy_d;
  logic [4:0] tok_cnt_q;
  logic [4:0] tok_cnt_d;
  logic [7:0] tok_cmd_q;
  logic [7:0] tok_cmd_d;
  logic       tok_q;
  // Command written while busy is dropped; software must poll first
  assign tok_wr    = wr && hit_tok && !busy_q && host_mode_q && !host_toggle; // R7
  assign tok_cmd_d = tok_wr ? apb_in.pwdata[7:0] : tok_cmd_q;
  assign busy_d    = host_toggle ? 1'b0 : (tok_wr ? 1'b1 : (tok_cnt_q == 5'd1 ? 1'b0 : busy_q));
  assign tok_cnt_d = host_toggle ? 5'd0 : (tok_wr ? 5'(`TOKEN_CYCLES) :
                     (tok_cnt_q != 5'd0 ? tok_cnt_q - 5'd1 : 5'd0));

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      busy_q    <= 1'b0;
      tok_cnt_q <= '0;
      tok_cmd_q <= '0;
      tok_q     <= 1'b0;
    end else begin
      busy_q    <= busy_d;
      tok_cnt_q <= tok_cnt_d;
      tok_cmd_q <= tok_cmd_d;
      tok_q     <= tok_wr;
    end
  end

  // --------------------------------------------------------------------------
  // Frame marker timer
  // --------------------------------------------------------------------------
  logic [31:0] frame_cnt_q;
  logic [31:0] frame_cnt_d;
  logic        sof_q;
  logic        sof_d;
  logic        sof_run;
  logic        frame_end;
  assign sof_run     = host_mode_q && enable_q && !host_toggle; // R3
  assign frame_end   = frame_cnt_q == FRAME_CYCLES - 1;
  assign frame_cnt_d = (!sof_run || frame_end) ? 32'h0000_0000 : frame_cnt_q + 32'h0000_0001;
  assign sof_d       = sof_run && frame_end; // R3

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      frame_cnt_q <= '0;
      sof_q       <= 1'b0;
    end else begin
      frame_cnt_q <= frame_cnt_d;
      sof_q       <= sof_d;
    end
  end

  // --------------------------------------------------------------------------
  // Resume signalling
  // --------------------------------------------------------------------------
  resume_state_e rs_q;
  resume_state_e rs_d;
  logic [7:0]    eop_cnt_q;
  logic [7:0]    eop_cnt_d;
  logic          eop_done;
  assign eop_done = eop_cnt_q == 8'(`LS_EOP_CYCLES - 1);

  always_comb begin
    rs_d      = rs_q;
    eop_cnt_d = 8'h00;
    if (host_toggle) begin
      rs_d = RS_IDLE;
    end else begin
      unique case (rs_q)
        RS_IDLE: if (resume_q) begin
          rs_d = RS_SIG;
        end
        RS_SIG: if (!resume_q) begin
          rs_d = host_mode_q ? RS_EOP : RS_IDLE; // R6
        end
        RS_EOP: begin
          eop_cnt_d = eop_cnt_q + 8'h01;
          if (eop_done) begin
            rs_d = RS_IDLE;
          end
        end
        default: rs_d = RS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rs_q      <= RS_IDLE;
      eop_cnt_q <= '0;
    end else begin
      rs_q      <= rs_d;
      eop_cnt_q <= eop_cnt_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read data and answer
  // --------------------------------------------------------------------------
  logic [31:0] rdata_d;
  logic [31:0] ctrl_word;
  logic [31:0] host_word;
  logic [31:0] stat_word;
  apb_rsp_s    rsp_q;
  assign ctrl_word = {29'h0, resume_q, 1'b0, enable_q};
  assign host_word = {28'h0, host_mode_q, 3'h0};
  assign stat_word = {24'h0, 2'h0, busy_q, 1'b0, 1'b0, eop_out, rs_q == RS_SIG, 1'b0};
  assign rdata_d   = hit_ctrl ? ctrl_word :
                     hit_host ? host_word :
                     hit_tok  ? {24'h0, tok_cmd_q} :
                     hit_stat ? stat_word : 32'h0000_0000;

  // Answer one cycle into the access phase; unmapped addresses error
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready  <= acc && !rsp_q.pready;
      rsp_q.pslverr <= acc && !rsp_q.pready && !mapped;
      rsp_q.prdata  <= (rd && !rsp_q.pready) ? rdata_d : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  logic resume_out_q;
  logic eop_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      resume_out_q <= 1'b0;
      eop_q        <= 1'b0;
    end else begin
      resume_out_q <= rs_d == RS_SIG;
      eop_q        <= rs_d == RS_EOP; // R6
    end
  end

  assign apb_out       = rsp_q;
  assign module_en_out = module_en_q;
  assign sof_out       = sof_q;
  assign host_rst_out  = host_rst_q;
  assign resume_out    = resume_out_q;
  assign eop_out       = eop_q;
  assign odd_ptr_out   = odd_ptr_q;
  assign token_out     = tok_q;
  assign token_cmd_out = tok_cmd_q;

endmodule

//--- core/usb_ctl_defs.svh
// Offsets, field positions, reset values and timing counts of the USB control block.
// Assumes a 100 MHz core clock and a 32-bit APB register bus.
`ifndef USB_CTL_DEFS_SVH
`define USB_CTL_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFF_USB_CONTROL   12'h000
`define OFF_HOST_CONFIG   12'h004
`define OFF_TOKEN_CMD     12'h008
`define OFF_LINK_STATUS   12'h00c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_ENABLE        0
`define BIT_PP_RESET      1
`define BIT_RESUME        2
`define BIT_HOST_MODE     3
`define BIT_TOKEN_BUSY    5
`define CTRL_RESET        32'h0000_0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ           100
`define FRAME_US          1000
`define FRAME_CYCLES      (`FRAME_US * `CLK_MHZ)
`define LS_EOP_NS         1330
`define LS_EOP_CYCLES     ((`LS_EOP_NS * `CLK_MHZ) / 1000)
`define TOKEN_CYCLES      16

`endif

//--- core/usb_ctl_pkg.sv
// Types shared by the USB control block.
// Assumes usb_ctl_defs.svh carries all numeric constants.
package usb_ctl_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_SIG  = 2'b01,
    RS_EOP  = 2'b10
  } resume_state_e;

endpackage

//--- tb/usb_ctl_properties.sv
// Port checker for the USB control block.
// Assumes a bind to usb_ctl; shadows follow APB writes.
`timescale 1ns/1ps
`include "usb_ctl_defs.svh"
module usb_ctl_properties #(
  parameter int unsigned FRAME_CYCLES = 50,
  parameter int unsigned NUM_EP       = 16
) (
  input wire logic                  core_clk_in,   // Clock
  input wire logic                  rst_in,        // Reset
  input wire usb_ctl_pkg::apb_req_s apb_in,        // Request
  input wire usb_ctl_pkg::apb_rsp_s apb_out,       // Answer
  input wire logic                  module_en_out, // Enable
  input wire logic                  sof_out,       // Frame
  input wire logic                  host_rst_out,  // Host reset
  input wire logic                  resume_out,    // Resume
  input wire logic                  eop_out,       // EOP
  input wire logic [NUM_EP-1:0]     odd_ptr_out    // Pointers
);
  import usb_ctl_pkg::*;
  localparam int unsigned EOPN = `LS_EOP_CYCLES;
  logic        en_q, host_q, run_q;
  logic [31:0] gap_q, len_q;
  wire wr   = apb_in.psel & apb_in.penable & apb_in.pwrite & apb_out.pready;
  wire wr_c = wr & (apb_in.paddr == `OFF_USB_CONTROL);
  wire wr_h = wr & (apb_in.paddr == `OFF_HOST_CONFIG);
  wire on   = en_q & host_q;
  always_ff @(posedge core_clk_in) begin
    en_q   <= rst_in ? 1'b0 : (wr_c ? apb_in.pwdata[0] : en_q);
    host_q <= rst_in ? 1'b0 : (wr_h ? apb_in.pwdata[3] : host_q);
    run_q  <= ~rst_in & on & (sof_out | run_q);
    gap_q  <= sof_out ? 32'h0 : gap_q + 32'h1;
    len_q  <= eop_out ? len_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_pp;
    wr_c ##0 apb_in.pwdata[1];
  endsequence
  sequence s_res_end;
    $fell(resume_out) ##0 host_q;
  endsequence
  property p_pp;
    s_pp |-> ##[1:2] (odd_ptr_out == '0);
  endproperty
  property p_en;
    (en_q & ~host_q) [*3] |-> module_en_out;
  endproperty
  property p_dis;
    (~en_q | host_q) [*3] |-> ~module_en_out;
  endproperty
  property p_sof;
    sof_out & run_q |-> gap_q == FRAME_CYCLES - 1;
  endproperty
  property p_sof_off;
    (~on) [*3] |-> ~sof_out;
  endproperty
  property p_hrst;
    wr_h & (apb_in.pwdata[3] != host_q) |-> ##[1:2] host_rst_out;
  endproperty
  property p_eop;
    s_res_end |-> ##[0:2] eop_out;
  endproperty
  property p_eop_len;
    $fell(eop_out) |-> len_q == EOPN;
  endproperty
  property p_rdy;
    apb_out.pready |=> ~apb_out.pready;
  endproperty
  a_pp: assert property (p_pp) else $error("pointers not reset");
  a_en: assert property (p_en) else $error("module not enabled");
  a_dis: assert property (p_dis) else $error("module not disabled");
  a_sof: assert property (p_sof) else $error("frame period wrong");
  a_sof_off: assert property (p_sof_off) else $error("frame marker while off");
  a_hrst: assert property (p_hrst) else $error("no host reset pulse");
  a_eop: assert property (p_eop) else $error("no EOP after resume");
  a_eop_len: assert property (p_eop_len) else $error("EOP length wrong");
  a_rdy: assert property (p_rdy) else $error("pready longer than one cycle");
endmodule
bind usb_ctl usb_ctl_properties #(.FRAME_CYCLES(FRAME_CYCLES), .NUM_EP(NUM_EP)) u_props (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .apb_in(apb_in), .apb_out(apb_out),
  .module_en_out(module_en_out), .sof_out(sof_out), .host_rst_out(host_rst_out),
  .resume_out(resume_out), .eop_out(eop_out), .odd_ptr_out(odd_ptr_out));

//--- tb/usb_bus_partner.sv
// Far-side bus observer: counts frame markers and EOP cycles.
// Assumes bus outputs synchronous to core_clk_in.
`timescale 1ns/1ps
module usb_bus_partner (
  input  wire logic   core_clk_in, // Clock
  input  wire logic   rst_in,      // Reset
  input  wire logic   sof_in,      // Frame marker
  input  wire logic   eop_in,      // EOP drive
  output logic [31:0] sof_cnt_out, // Markers seen
  output logic [31:0] eop_cnt_out  // EOP cycles seen
);
  always_ff @(posedge core_clk_in) begin
    sof_cnt_out <= rst_in ? 32'h0 : sof_cnt_out + {31'h0, sof_in};
    eop_cnt_out <= rst_in ? 32'h0 : eop_cnt_out + {31'h0, eop_in};
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the USB control block.
// Assumes usb_ctl, its checker and the bus partner compiled first.
`timescale 1ns/1ps
`include "usb_ctl_defs.svh"
module testbench;
  import usb_ctl_pkg::*;
  localparam int unsigned FRAME = 50;
  localparam int          HOLD  = 40;
  logic        core_clk_in, rst_in, mod_en, sof, hrst, res, eop, tok, err;
  apb_req_s    req;
  apb_rsp_s    rsp;
  logic [15:0] odd, exp_odd;
  logic [7:0]  tcmd;
  logic [3:0]  ep;
  logic [31:0] sof_n, eop_n, rd;
  int          err_count, total_checks, hrst_n, tok_n, seed, k, n;
  usb_ctl #(.FRAME_CYCLES(FRAME), .NUM_EP(16)) DUT (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .apb_in(req), .apb_out(rsp),
    .module_en_out(mod_en), .sof_out(sof), .host_rst_out(hrst), .resume_out(res),
    .eop_out(eop), .odd_ptr_out(odd), .token_out(tok), .token_cmd_out(tcmd));
  usb_bus_partner u_bus (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .sof_in(sof), .eop_in(eop),
    .sof_cnt_out(sof_n), .eop_cnt_out(eop_n));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) if (hrst === 1'b1) hrst_n++;
  always @(posedge core_clk_in) if (tok === 1'b1) tok_n++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int c;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk_in);
    req.penable <= 1'b1;
    c = 0;
    do begin
      @(posedge core_clk_in);
      c++;
    end while (rsp.pready !== 1'b1 && c < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (c == 20) begin
      err_count++;
      print_verdict();
    end
    @(posedge core_clk_in);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  initial begin
    seed = 32;
    hrst_n = 0;
    tok_n = 0;
    req = '0;
    rst_in = 1'b1;
    exp_odd = '0;
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    for (k = 0; k < 4; k++) rdchk(12'(k * 4), 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `OFF_USB_CONTROL, 32'h1);
    chk(mod_en, 1'b1);
    apb(1'b1, `OFF_USB_CONTROL, 32'h0);
    chk(mod_en, 1'b0);
    apb(1'b1, `OFF_HOST_CONFIG, 32'h8);
    for (k = 0; k < 4; k++) begin
      ep = 4'($random(seed));
      apb(1'b1, `OFF_TOKEN_CMD, {24'h0, 4'h9, ep});
      apb(1'b1, `OFF_TOKEN_CMD, {24'h0, 4'h9, ~ep});
      exp_odd[ep] = ~exp_odd[ep];
      chk(odd, exp_odd);
      chk({24'h0, tcmd}, {24'h0, 4'h9, ep});
      rdchk(`OFF_TOKEN_CMD, {24'h0, 4'h9, ep});
      apb(1'b0, `OFF_LINK_STATUS, 32'h0);
      chk(rd[5], 1'b1);
      for (n = 0; n < 10 && rd[5] !== 1'b0; n++) apb(1'b0, `OFF_LINK_STATUS, 32'h0);
      chk(rd[5], 1'b0);
    end
    chk(tok_n, 4);
    chk(hrst_n, 1);
    apb(1'b1, `OFF_USB_CONTROL, 32'h3);
    chk(odd, 16'h0);
    chk(mod_en, 1'b0);
    rdchk(`OFF_USB_CONTROL, 32'h1);
    repeat (3 * FRAME + 10) @(posedge core_clk_in);
    chk(sof_n, 3);
    apb(1'b1, `OFF_USB_CONTROL, 32'h0);
    repeat (2 * FRAME) @(posedge core_clk_in);
    chk(sof_n, 3);
    apb(1'b1, `OFF_USB_CONTROL, 32'h4);
    repeat (HOLD) @(posedge core_clk_in);
    chk(res, 1'b1);
    rdchk(`OFF_LINK_STATUS, 32'h2);
    apb(1'b1, `OFF_USB_CONTROL, 32'h0);
    repeat (150) @(posedge core_clk_in);
    chk(eop_n, `LS_EOP_CYCLES);
    apb(1'b1, `OFF_HOST_CONFIG, 32'h0);
    repeat (2) @(posedge core_clk_in);
    chk(hrst_n, 2);
    apb(1'b1, `OFF_USB_CONTROL, 32'h4);
    repeat (HOLD) @(posedge core_clk_in);
    apb(1'b1, `OFF_USB_CONTROL, 32'h0);
    repeat (150) @(posedge core_clk_in);
    chk(res, 1'b0);
    chk(eop_n, `LS_EOP_CYCLES);
    print_verdict();
  end
endmodule
